//--- hw/mft_pkg.sv
package mft_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [9:0] IDX_STATUS_CONTROL = 10'h008;
  localparam logic [9:0] IDX_COUNT_LOW = 10'h009;
  localparam int ADDR_W = 12;

  // status/control field positions
  localparam int BIT_OVF_FLAG = 7;
  localparam int BIT_PER_FLAG = 6;
  localparam int BIT_OVF_EN = 5;
  localparam int BIT_PER_EN = 4;
  localparam int BIT_OVF_CLR = 3;
  localparam int BIT_PER_CLR = 2;
  localparam int BIT_RATE_HI = 1;
  localparam int BIT_RATE_LO = 0;

  // reset values
  localparam logic [1:0] RATE_RESET = 2'h3;

  // counter chain geometry
  localparam int PRESCALE_DIV = 4;
  localparam int PRESCALE_W = 2;
  localparam int CHAIN_W = 15;
  localparam int LOW_W = 8;
  // lowest chain bit whose carry-out marks rate 00 (2^14 clocks)
  localparam int RATE_BASE_BIT = 11;

  // watchdog: timeout on the ninth periodic tick after a clear
  localparam int WDOG_W = 4;
  localparam logic [3:0] WDOG_LAST = 4'h8;

  // power-on startup lengths in clock cycles
  localparam int STARTUP_LONG_CYC = 4064;
  localparam int STARTUP_SHORT_CYC = 16;
  localparam int STARTUP_W = 12;
  localparam logic [11:0] STARTUP_LONG_LAST = 12'(STARTUP_LONG_CYC - 1);
  localparam logic [11:0] STARTUP_SHORT_LAST = 12'(STARTUP_SHORT_CYC - 1);

  typedef enum logic {MFT_STARTUP, MFT_RUN} mft_phase_e;

  // software control fields
  typedef struct packed {
    logic ovf_en;
    logic per_en;
    logic [1:0] rate;
  } mft_ctrl_s;

  // hardware flags
  typedef struct packed {
    logic ovf;
    logic per;
  } mft_flags_s;
endpackage

//--- hw/mft_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module mft_prescaler (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic clear,
  // one-cycle enable every fourth clock
  output logic tick
);
  logic [mft_pkg::PRESCALE_W-1:0] div;

  ////////////////////////////////////////////////////////////////////////
  // free divider; tick lands when the divider wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= '0;
      tick <= 1'b0;
    end else if (clear) begin
      div <= '0;
      tick <= 1'b0;
    end else begin
      div <= div + 2'h1;
      tick <= (div == 2'(mft_pkg::PRESCALE_DIV - 1));
    end
  end
endmodule
`default_nettype wire

//--- hw/mft_watchdog.sv
`timescale 1ns/10ps
`default_nettype none
module mft_watchdog (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // periodic tick and clears
  input wire logic tick,
  input wire logic clear,
  // status
  output logic [mft_pkg::WDOG_W-1:0] count,
  output logic timeout
);
  ////////////////////////////////////////////////////////////////////////
  // counts periodic ticks; a clear mid-interval costs up to one interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      timeout <= 1'b0;
    end else if (clear) begin
      count <= '0;
      timeout <= 1'b0;
    end else begin
      timeout <= tick && (count == mft_pkg::WDOG_LAST);
      if (tick) begin
        count <= (count == mft_pkg::WDOG_LAST) ? '0 : count + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- hw/mft_top.sv
`timescale 1ns/10ps
`default_nettype none
module mft_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mft_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor side controls
  input wire logic short_startup_option,
  input wire logic stop_instr,
  input wire logic wait_mode,
  input wire logic global_irq_mask,
  input wire logic watchdog_clear,
  // requests and status
  output logic overflow_irq,
  output logic periodic_interrupt,
  output logic wake_request,
  output logic watchdog_timeout,
  output logic startup_busy
);
  mft_pkg::mft_phase_e phase;
  mft_pkg::mft_ctrl_s ctrl;
  mft_pkg::mft_flags_s flags;
  logic [mft_pkg::CHAIN_W-1:0] chain;
  logic [mft_pkg::STARTUP_W-1:0] startup_cnt;
  logic short_strap;
  logic strap_taken;
  logic pre_tick;
  logic chain_clear;
  logic ovf_event;
  logic per_event;
  logic wr_access;
  logic rd_access;
  logic wr_status;
  logic wdog_timeout;
  logic [mft_pkg::WDOG_W-1:0] wdog_count;
  logic [mft_pkg::LOW_W-1:0] status_byte;
  logic [3:0] tap_carry;
  logic next_ovf_irq;
  logic next_per_irq;

  ////////////////////////////////////////////////////////////////////////
  // decode helper shared by the read and write paths
  function automatic logic addr_hit(input logic [mft_pkg::ADDR_W-1:0] a,
                                    input logic [9:0] idx);
    addr_hit = (a[11:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // prescaler and watchdog
  // stop and startup end both restart the whole chain from zero
  assign chain_clear = stop_instr ||
                       (phase == mft_pkg::MFT_STARTUP && strap_taken &&
                        startup_cnt == (short_strap ? mft_pkg::STARTUP_SHORT_LAST
                                                    : mft_pkg::STARTUP_LONG_LAST));

  mft_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .clear(chain_clear),
    .tick(pre_tick)
  );

  mft_watchdog u_watchdog (
    .pclk(pclk),
    .presetn(presetn),
    .tick(per_event),
    .clear(watchdog_clear || chain_clear),
    .count(wdog_count),
    .timeout(wdog_timeout)
  );

  ////////////////////////////////////////////////////////////////////////
  // startup strap caught after reset release, never in the reset branch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_strap <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      short_strap <= short_startup_option;
      strap_taken <= 1'b1;
    end
  end

  // startup phase: counter runs, takes one more step as the hold releases and the chain is cleared, then keeps its value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= mft_pkg::MFT_STARTUP;
      startup_cnt <= '0;
      startup_busy <= 1'b1;
    end else begin
      case (phase)
        mft_pkg::MFT_STARTUP: begin
          if (strap_taken) begin
            startup_cnt <= startup_cnt + 12'h001;
          end
          if (chain_clear && !stop_instr) begin
            phase <= mft_pkg::MFT_RUN;
            startup_busy <= 1'b0;
          end
        end
        mft_pkg::MFT_RUN: begin
          startup_busy <= 1'b0;
        end
        default: begin
          phase <= mft_pkg::MFT_STARTUP;
          startup_cnt <= '0;
          startup_busy <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // synchronous chain, one step per prescaler tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain <= '0;
    end else if (chain_clear) begin
      chain <= '0;
    end else if (pre_tick) begin
      chain <= chain + 15'h0001;
    end
  end

  // overflow event when the low eight stages roll from all ones
  assign ovf_event = pre_tick && !chain_clear &&
                     (chain[mft_pkg::LOW_W-1:0] == 8'hFF);

  // carries out of stage 11..14 give the four periodic taps
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_tap
      assign tap_carry[gi] = &chain[mft_pkg::RATE_BASE_BIT+gi:0];
    end
  endgenerate

  assign per_event = pre_tick && !chain_clear && tap_carry[ctrl.rate];

  ////////////////////////////////////////////////////////////////////////
  // apb access qualifiers; one wait state, write lands with pready
  assign wr_access = psel && penable && pready && pwrite;
  assign rd_access = psel && penable && !pready && !pwrite;
  assign wr_status = wr_access && addr_hit(paddr, mft_pkg::IDX_STATUS_CONTROL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  // software control fields; stop drops the enables but keeps the rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl.ovf_en <= 1'b0;
      ctrl.per_en <= 1'b0;
      ctrl.rate <= mft_pkg::RATE_RESET;
    end else if (stop_instr) begin
      ctrl.ovf_en <= 1'b0;
      ctrl.per_en <= 1'b0;
    end else if (wr_status) begin
      ctrl.ovf_en <= pwdata[mft_pkg::BIT_OVF_EN];
      ctrl.per_en <= pwdata[mft_pkg::BIT_PER_EN];
      ctrl.rate <= {pwdata[mft_pkg::BIT_RATE_HI], pwdata[mft_pkg::BIT_RATE_LO]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags: set beats a same-cycle clear; writes to flag bits are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else if (stop_instr) begin
      flags <= '0;
    end else begin
      flags.ovf <= ovf_event ||
                   (flags.ovf && !(wr_status && pwdata[mft_pkg::BIT_OVF_CLR]));
      flags.per <= per_event ||
                   (flags.per && !(wr_status && pwdata[mft_pkg::BIT_PER_CLR]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // readback image; clear bits are never stored and read as zero
  always_comb begin
    status_byte = '0;
    status_byte[mft_pkg::BIT_OVF_FLAG] = flags.ovf;
    status_byte[mft_pkg::BIT_PER_FLAG] = flags.per;
    status_byte[mft_pkg::BIT_OVF_EN] = ctrl.ovf_en;
    status_byte[mft_pkg::BIT_PER_EN] = ctrl.per_en;
    status_byte[mft_pkg::BIT_OVF_CLR] = 1'b0;
    status_byte[mft_pkg::BIT_PER_CLR] = 1'b0;
    status_byte[mft_pkg::BIT_RATE_HI] = ctrl.rate[1];
    status_byte[mft_pkg::BIT_RATE_LO] = ctrl.rate[0];
  end

  // read data and error are captured in the cycle before pready rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      prdata <= '0;
      pslverr <= !(addr_hit(paddr, mft_pkg::IDX_STATUS_CONTROL) ||
                   addr_hit(paddr, mft_pkg::IDX_COUNT_LOW));
      if (rd_access && addr_hit(paddr, mft_pkg::IDX_STATUS_CONTROL)) begin
        prdata <= {24'h000000, status_byte};
      end else if (rd_access && addr_hit(paddr, mft_pkg::IDX_COUNT_LOW)) begin
        prdata <= {24'h000000, chain[mft_pkg::LOW_W-1:0]};
      end
    end else begin
      prdata <= '0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // requests; the global mask gates the requests but not the wake
  assign next_ovf_irq = flags.ovf && ctrl.ovf_en;
  assign next_per_irq = flags.per && ctrl.per_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq <= 1'b0;
      periodic_interrupt <= 1'b0;
      wake_request <= 1'b0;
      watchdog_timeout <= 1'b0;
    end else begin
      overflow_irq <= next_ovf_irq && !global_irq_mask;
      periodic_interrupt <= next_per_irq && !global_irq_mask;
      wake_request <= wait_mode && (next_ovf_irq || next_per_irq);
      watchdog_timeout <= wdog_timeout;
    end
  end
endmodule
`default_nettype wire

//--- bench/mft_sva.sv
`timescale 1ns/10ps
`default_nettype none
module mft_sva (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // controls and status
  input wire logic stop_instr,
  input wire logic wait_mode,
  input wire logic global_irq_mask,
  input wire logic overflow_irq,
  input wire logic periodic_interrupt,
  input wire logic wake_request,
  input wire logic watchdog_timeout,
  input wire logic startup_busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // requests are one cycle late, so the mask is seen through $past
  property p_ovf_mask;
    $past(global_irq_mask) |-> !overflow_irq;
  endproperty
  a_ovf_mask: assert property (p_ovf_mask) else $error("overflow request while masked");
  property p_per_mask;
    $past(global_irq_mask) |-> !periodic_interrupt;
  endproperty
  a_per_mask: assert property (p_per_mask) else $error("periodic request while masked");
  property p_wake;
    $past(wait_mode) && (overflow_irq || periodic_interrupt) |-> wake_request;
  endproperty
  a_wake: assert property (p_wake) else $error("enabled request did not wake");
  property p_no_wake;
    !$past(wait_mode) |-> !wake_request;
  endproperty
  a_no_wake: assert property (p_no_wake) else $error("wake outside wait mode");
  property p_stop;
    stop_instr |-> ##2 !overflow_irq && !periodic_interrupt;
  endproperty
  a_stop: assert property (p_stop) else $error("request survived stop");
  property p_startup_once;
    !startup_busy |=> !startup_busy;
  endproperty
  a_startup_once: assert property (p_startup_once) else $error("startup restarted");
  property p_wdog_pulse;
    watchdog_timeout |=> !watchdog_timeout;
  endproperty
  a_wdog_pulse: assert property (p_wdog_pulse) else $error("timeout pulse too long");
  property p_ready_time;
    psel && penable && !$past(penable) |=> pready ##1 !pready;
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("bus answer late or long");
  property p_idle_bus;
    !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_idle_bus: assert property (p_idle_bus) else $error("bus data outside answer");
endmodule
`default_nettype wire

//--- bench/mft_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module mft_cpu_model (
  // clock
  input wire logic pclk,
  // request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [mft_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  // answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = 32'h0;
  end
  ////////////////////////////////////////////////////////////////
  // one transfer; released address and data show inverted values, not stale ones
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

//--- bench/multifunction_timebase_timer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module multifunction_timebase_timer_tb_top;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic short_startup_option, stop_instr, wait_mode, global_irq_mask, watchdog_clear;
  logic overflow_irq, periodic_interrupt, wake_request, watchdog_timeout, startup_busy;
  logic [7:0] c, d;
  logic [1:0] b;
  logic wd_seen = 1'b0;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int n, g;
  localparam logic [11:0] A_SC = {mft_pkg::IDX_STATUS_CONTROL, 2'h0};
  localparam logic [11:0] A_CNT = {mft_pkg::IDX_COUNT_LOW, 2'h0};
  mft_top mft_top_i(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .short_startup_option, .stop_instr, .wait_mode, .global_irq_mask,
    .watchdog_clear, .overflow_irq, .periodic_interrupt, .wake_request, .watchdog_timeout,
    .startup_busy);
  mft_cpu_model mft_cpu_model_i(.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  always #10 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  // hang guard, set well above the longest test
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    // regular clears must keep the watchdog from ever timing out
    if (watchdog_timeout !== 1'b0 && presetn === 1'b1)
      wd_seen <= 1'b1;
    if (cyc == 70000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    mft_cpu_model_i.xfer(1'b1, a, v, q, e);
  endtask
  task automatic rd(input logic [11:0] a);
    mft_cpu_model_i.xfer(1'b0, a, 32'h0, q, e);
  endtask
  // bounded wait for a level
  task automatic wt(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // spacing of two events; clearing costs seven edges of the count
  task automatic period(ref logic s, input logic [31:0] clr, input int exp);
    wt(s, 1'b1, exp + 100);
    wr(A_SC, clr);
    repeat (3) @(posedge pclk);
    wt(s, 1'b1, exp + 100);
    chk(n + 7, exp, "event period");
  endtask
  function automatic logic [31:0] sc(logic fo, logic fp, logic eo, logic ep, logic [1:0] r);
    return {24'h0, fo, fp, eo, ep, 2'h0, r};
  endfunction
  task automatic pet();
    watchdog_clear <= 1'b1;
    @(posedge pclk);
    watchdog_clear <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {presetn, stop_instr, wait_mode, global_irq_mask, watchdog_clear} = 5'h0;
    short_startup_option = 1'b1;
    void'($urandom(32'hC8D1EC7F));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wt(startup_busy, 1'b0, 40);
    chk(n inside {[16:20]}, 1, "startup length");
    rd(A_SC);
    chk(q, sc(0, 0, 0, 0, 2'h3), "reset value");
    // random gaps between count reads; read capture spans gap plus four
    for (int i = 0; i < 4; i++) begin
      g = 8 + $urandom % 64;
      rd(A_CNT);
      c = q[7:0];
      repeat (g) @(posedge pclk);
      rd(A_CNT);
      d = q[7:0] - c;
      chk((d == 8'((g + 4) >> 2) || d == 8'((g + 7) >> 2)) && q[31:8] == 0, 1, "count");
    end
    $display("test count done");
    for (int r = 0; r < 4; r++) begin
      pet();
      b = 2'($urandom);
      wr(A_SC, {24'($urandom), 2'h3, b, 2'h0, 2'(r)});
      rd(A_SC);
      chk(q & 32'h3F, sc(0, 0, b[1], b[0], 2'(r)), "rate select");
    end
    $display("test rates done");
    global_irq_mask <= 1'b1;
    wait_mode <= 1'b1;
    wr(A_SC, 32'h2F);
    wt(wake_request, 1'b1, 1100);
    chk(overflow_irq, 0, "masked request");
    chk(wake_request, 1, "wake");
    global_irq_mask <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(overflow_irq, 1, "overflow request");
    wr(A_SC, 32'h2F);
    wr(A_SC, 32'hE3);
    rd(A_SC);
    chk(q, sc(0, 0, 1, 0, 2'h3), "flag write ignored");
    chk(overflow_irq | wake_request, 0, "request dropped");
    period(overflow_irq, 32'h2B, 1024);
    $display("test overflow done");
    pet();
    wr(A_SC, 32'h1C);
    wt(periodic_interrupt, 1'b1, 140000);
    wr(A_SC, 32'h1C);
    repeat (3) @(posedge pclk);
    period(periodic_interrupt, 32'h14, 16384);
    $display("test periodic done");
    stop_instr <= 1'b1;
    @(posedge pclk);
    stop_instr <= 1'b0;
    rd(A_SC);
    chk(q, sc(0, 0, 0, 0, 2'h0), "stop clears");
    rd(A_CNT);
    chk(q < 32'h4, 1, "stop clears count");
    for (int i = 0; i < 2; i++) begin
      rd(i ? 12'h021 : 12'h030);
      chk({q[30:0], e}, 32'h1, "refused access");
    end
    $display("test stop and refusal done");
    chk(wd_seen, 0, "watchdog timeout despite clears");
    test_done();
  end
endmodule
bind mft_top mft_sva mft_sva_i(.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
  .stop_instr, .wait_mode, .global_irq_mask, .overflow_irq, .periodic_interrupt,
  .wake_request, .watchdog_timeout, .startup_busy);
`default_nettype wire
